/* hw/bsq_pkg.sv */
package bsq_pkg;
    // clock and tick timing
    localparam int unsigned CLK_NS = 20; // control clock period
    localparam int unsigned TICK_MS = 10; // one delay unit
    localparam int unsigned TICK_CYC = (TICK_MS * 1000000) / CLK_NS; // cycles per unit
    localparam int unsigned HOLD_MS = 1000; // warning hold after overtravel ends
    localparam int unsigned HOLD_TICKS = HOLD_MS / TICK_MS; // hold in units
    // register byte offsets
    localparam logic [4:0] A_OTW = 5'h00; // overtravel_warning_setup
    localparam logic [4:0] A_ROUTE = 5'h04; // brake_output_routing
    localparam logic [4:0] A_DLY = 5'h08; // brake_power_off_delay
    localparam logic [4:0] A_THR = 5'h0c; // brake_speed_threshold
    localparam logic [4:0] A_WAIT = 5'h10; // brake_wait_timeout
    localparam logic [4:0] A_STAT = 5'h14; // read-only status
    // field positions
    localparam int unsigned OTW_LSB = 12; // warning-enable digit
    localparam int unsigned ROUTE_LSB = 8; // allocation digit
    localparam logic [3:0] OTW_ON = 4'h1; // digit value that enables detection
    // values after reset, except routing, which keeps its setting
    localparam logic [15:0] OTW_RST = 16'h0000;
    localparam logic [15:0] ROUTE_RST = 16'h0000;
    localparam logic [15:0] DLY_RST = 16'h0000;
    localparam logic [15:0] THR_RST = 16'h0064;
    localparam logic [15:0] WAIT_RST = 16'h0032;
    // legal ranges
    localparam logic [15:0] DLY_MAX = 16'h0032;
    localparam logic [15:0] THR_MAX = 16'h2710;
    localparam logic [15:0] WAIT_MIN = 16'h000a;
    localparam logic [15:0] WAIT_MAX = 16'h0064;
    // brake sequencer modes
    typedef enum logic [1:0] {BSQ_OFF, BSQ_ON, BSQ_DLY, BSQ_ROT} bsq_mode_t;
endpackage

/* hw/bsq_route_if.sv */
`timescale 1ns/10ps
// brake signal routed onto the output terminal pairs
interface bsq_route_if;
    logic brake; // brake release level
    logic [2:0] other; // other signals already on each terminal
    logic [1:0] sel; // working allocation copy
    logic [2:0] term; // resulting terminal levels
    modport src(output brake, output other, output sel, input term);
    modport router(input brake, input other, input sel, output term);
endinterface

/* hw/bsq_out_router.sv */
`timescale 1ns/10ps
module bsq_out_router
(
    bsq_route_if.router rt
);
    // allocation 0 drives no terminal, 1..3 picks a pair, shared pairs are or-ed
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            rt.term[i] = rt.other[i] | (rt.brake & (rt.sel == 2'(i + 1))); // R08 R09 R10
        end
    end
endmodule

/* hw/bsq_sequencer.sv */
`timescale 1ns/10ps
// Summary of operation
// R01: warning raised only when enable digit is one
// R02: warning is report only, blocks nothing
// R03: overtravel input starts overtravel stop processing
// R04: host waits 50 ms after release
// R05: brake output active releases, inactive applies
// R06: alarm or servo-off deasserts brake output
// R07: brake stays released during overtravel
// R08: allocation zero drives brake nowhere
// R09: allocation 1..3 selects terminal pair
// R10: shared terminals carry or of signals
// R11: stopped servo-off drops brake same cycle
// R12: power-off delay 0..50 units of 10 ms
// R13: delay applies only for stopped servo-off
// R14: alarm removes motor power immediately
// R15: vertical axis: power off after brake engages
// R16: rotating: brake applies below speed threshold
// R17: rotating: brake applies after wait timeout
// R18: warning held one second after overtravel ends
// R19: warning only in reference direction, power on
// R20: restart fields sampled at reset release
// R21: delay counts whole 10 ms ticks
module bsq_sequencer
#(
    parameter int unsigned TICK_CYCLES = bsq_pkg::TICK_CYC, // cycles per 10 ms unit
    parameter int unsigned SPD_W = 14 // motor speed width, rpm
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic servo_on_in,
    input wire logic alarm_in,
    input wire logic fwd_limit_in,
    input wire logic rev_limit_in,
    input wire logic [SPD_W-1:0] motor_speed,
    input wire logic ref_fwd,
    input wire logic ref_rev,
    input wire logic [2:0] other_out,
    output logic [2:0] term_out,
    output logic brake_release_out,
    output logic motor_power_on,
    output logic ot_stop_fwd,
    output logic ot_stop_rev,
    output logic ot_warning
);
    localparam int unsigned DIV_W = $clog2(TICK_CYCLES + 1); // divider width
    localparam logic [DIV_W-1:0] DIV_END = DIV_W'(TICK_CYCLES - 1); // last cycle of a tick
    localparam logic [6:0] HOLD_END = 7'(bsq_pkg::HOLD_TICKS - 1); // last hold unit

    // whole block state, registered once per clock
    typedef struct packed {
        logic son_m, son_s; // servo-on synchroniser
        logic alm_m, alm_s; // alarm synchroniser
        logic fwd_m, fwd_s; // forward limit synchroniser
        logic rev_m, rev_s; // reverse limit synchroniser
        logic [15:0] otw_reg; // overtravel_warning_setup
        logic [15:0] route_reg; // brake_output_routing
        logic [15:0] dly_reg; // brake_power_off_delay
        logic [15:0] thr_reg; // brake_speed_threshold
        logic [15:0] wait_reg; // brake_wait_timeout
        logic [1:0] route_act; // allocation working copy
        bsq_pkg::bsq_mode_t mode; // sequencer mode
        logic [DIV_W-1:0] div; // 10 ms divider
        logic [15:0] units; // whole units in current mode
        logic [6:0] hold; // warning hold units
        logic warn; // warning flag
        logic ot_prev; // raw overtravel last cycle
        logic stop_fwd, stop_rev; // stop processing requests
        logic [15:0] rdata; // read data
    } bsq_st_t;

    bsq_st_t st_ff; // current state
    bsq_st_t nxt_st; // next state
    bsq_route_if rt(); // link to the terminal router

    // keep a setting inside its documented range
    function automatic logic [15:0] bsq_clamp(input logic [15:0] v, input logic [15:0] lo,
                                              input logic [15:0] hi);
        logic [15:0] r;
        r = v;
        if (v < lo)
        begin
            r = lo;
        end
        else if (v > hi)
        begin
            r = hi;
        end
        return r;
    endfunction

    logic tick; // last cycle of a 10 ms unit
    logic stopped; // motor at standstill
    logic pwr_on; // motor power applied
    logic raw_ot; // overtravel seen in reference direction
    logic warn_en; // detection enabled
    logic [15:0] dly_v; // clamped delay
    logic [15:0] thr_v; // clamped speed threshold
    logic [15:0] wait_v; // clamped wait

    // shared decode of the current state
    always_comb
    begin
        tick = (st_ff.div == DIV_END);
        stopped = (motor_speed == '0);
        pwr_on = (st_ff.mode == bsq_pkg::BSQ_ON) || (st_ff.mode == bsq_pkg::BSQ_DLY);
        // no reference means both directions count
        raw_ot = (st_ff.fwd_s & ~ref_rev) | (st_ff.rev_s & ~ref_fwd); // R19
        warn_en = (st_ff.otw_reg[bsq_pkg::OTW_LSB +: 4] == bsq_pkg::OTW_ON); // R01
        dly_v = bsq_clamp(st_ff.dly_reg, 16'h0000, bsq_pkg::DLY_MAX);
        thr_v = bsq_clamp(st_ff.thr_reg, 16'h0000, bsq_pkg::THR_MAX);
        wait_v = bsq_clamp(st_ff.wait_reg, bsq_pkg::WAIT_MIN, bsq_pkg::WAIT_MAX);
    end

    // next-state logic for the whole block
    always_comb
    begin
        nxt_st = st_ff;
        // two flops on the servo-on, alarm and both limit pins before use
        nxt_st.son_m = servo_on_in;
        nxt_st.son_s = st_ff.son_m;
        nxt_st.alm_m = alarm_in;
        nxt_st.alm_s = st_ff.alm_m;
        nxt_st.fwd_m = fwd_limit_in;
        nxt_st.fwd_s = st_ff.fwd_m;
        nxt_st.rev_m = rev_limit_in;
        nxt_st.rev_s = st_ff.rev_m;
        // free running unit divider
        nxt_st.div = tick ? '0 : st_ff.div + 1'b1; // R21
        // register writes
        if (reg_wr)
        begin
            unique case (reg_addr)
                bsq_pkg::A_OTW: nxt_st.otw_reg = reg_wdata;
                bsq_pkg::A_ROUTE: nxt_st.route_reg = reg_wdata;
                bsq_pkg::A_DLY: nxt_st.dly_reg = reg_wdata;
                bsq_pkg::A_THR: nxt_st.thr_reg = reg_wdata;
                bsq_pkg::A_WAIT: nxt_st.wait_reg = reg_wdata;
                default: ; // status and holes ignore writes
            endcase
        end
        // register reads, answer in the next cycle only
        nxt_st.rdata = '0;
        if (reg_rd)
        begin
            unique case (reg_addr)
                bsq_pkg::A_OTW: nxt_st.rdata = st_ff.otw_reg;
                bsq_pkg::A_ROUTE: nxt_st.rdata = st_ff.route_reg;
                bsq_pkg::A_DLY: nxt_st.rdata = st_ff.dly_reg;
                bsq_pkg::A_THR: nxt_st.rdata = st_ff.thr_reg;
                bsq_pkg::A_WAIT: nxt_st.rdata = st_ff.wait_reg;
                bsq_pkg::A_STAT: nxt_st.rdata = {7'h00, st_ff.stop_rev, st_ff.stop_fwd,
                                                 st_ff.warn, pwr_on, brake_release_out,
                                                 st_ff.route_act, st_ff.mode};
                default: nxt_st.rdata = '0; // unmapped reads as zero
            endcase
        end
        // units spent in the current mode
        if (tick)
        begin
            nxt_st.units = st_ff.units + 16'h0001; // R21
        end
        // brake and power sequencing
        unique case (st_ff.mode)
            bsq_pkg::BSQ_OFF:
            begin
                nxt_st.units = '0;
                if (st_ff.son_s && !st_ff.alm_s)
                begin
                    nxt_st.mode = bsq_pkg::BSQ_ON; // R05
                end
            end
            bsq_pkg::BSQ_ON:
            begin
                nxt_st.units = '0;
                // overtravel alone never leaves this mode
                if (st_ff.alm_s) // R07
                begin
                    // power drops at once, delay ignored
                    nxt_st.mode = stopped ? bsq_pkg::BSQ_OFF : bsq_pkg::BSQ_ROT; // R06 R14
                end
                else if (!st_ff.son_s)
                begin
                    if (!stopped)
                    begin
                        nxt_st.mode = bsq_pkg::BSQ_ROT; // R13
                    end
                    else if (dly_v == '0)
                    begin
                        nxt_st.mode = bsq_pkg::BSQ_OFF; // R21
                    end
                    else
                    begin
                        nxt_st.mode = bsq_pkg::BSQ_DLY; // R11 R12
                    end
                end
            end
            bsq_pkg::BSQ_DLY:
            begin
                // brake applied, power held for the programmed units
                if (st_ff.alm_s || (st_ff.units >= dly_v))
                begin
                    nxt_st.mode = bsq_pkg::BSQ_OFF; // R12 R14
                end
            end
            bsq_pkg::BSQ_ROT:
            begin
                // power off, brake held released until slow or timed out
                if ((16'(motor_speed) < thr_v) || (st_ff.units >= wait_v))
                begin
                    nxt_st.mode = bsq_pkg::BSQ_OFF; // R16 R17
                end
            end
        endcase
        // overtravel stop processing follows the limits directly
        nxt_st.stop_fwd = st_ff.fwd_s; // R03
        nxt_st.stop_rev = st_ff.rev_s; // R03
        // warning: set on a new overtravel with power on, held after it ends
        nxt_st.ot_prev = raw_ot;
        if (!warn_en)
        begin
            nxt_st.warn = 1'b0; // R01
            nxt_st.hold = '0;
        end
        else if (raw_ot && !st_ff.ot_prev && pwr_on)
        begin
            nxt_st.warn = 1'b1; // R19
            nxt_st.hold = '0;
        end
        else if (st_ff.warn && raw_ot)
        begin
            nxt_st.hold = '0;
        end
        else if (st_ff.warn && tick)
        begin
            nxt_st.hold = st_ff.hold + 7'h01;
            if (st_ff.hold == HOLD_END)
            begin
                nxt_st.warn = 1'b0; // R18
            end
        end
        // synchronous reset; routing setting survives a restart
        if (sys_rst)
        begin
            nxt_st = '0;
            nxt_st.otw_reg = bsq_pkg::OTW_RST;
            nxt_st.route_reg = st_ff.route_reg;
            nxt_st.dly_reg = bsq_pkg::DLY_RST;
            nxt_st.thr_reg = bsq_pkg::THR_RST;
            nxt_st.wait_reg = bsq_pkg::WAIT_RST;
            nxt_st.route_act = st_ff.route_reg[bsq_pkg::ROUTE_LSB +: 2]; // R20
            nxt_st.mode = bsq_pkg::BSQ_OFF;
        end
    end

    // single state register
    always_ff @(posedge clk)
    begin
        st_ff <= nxt_st;
    end

    // outputs from the state register, term_out also or-ed with other_out
    assign reg_rdata = st_ff.rdata;
    assign brake_release_out = (st_ff.mode == bsq_pkg::BSQ_ON) || (st_ff.mode == bsq_pkg::BSQ_ROT);
    assign motor_power_on = pwr_on;
    assign ot_stop_fwd = st_ff.stop_fwd;
    assign ot_stop_rev = st_ff.stop_rev;
    assign ot_warning = st_ff.warn; // R02
    assign rt.brake = brake_release_out;
    assign rt.other = other_out;
    assign rt.sel = st_ff.route_act;
    assign term_out = rt.term;

    // terminal router
    bsq_out_router u_router
    (
        .rt(rt)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    warn_enable_a: assert property (!warn_en |=> !ot_warning) // R01
        else $error("warning set while disabled");
    alarm_brake_a: assert property (st_ff.mode == bsq_pkg::BSQ_ON && st_ff.alm_s && stopped
        |=> !brake_release_out && !motor_power_on) // R06
        else $error("alarm did not apply brake and drop power");
    servo_off_a: assert property (st_ff.mode == bsq_pkg::BSQ_ON && !st_ff.son_s && stopped
        |=> !brake_release_out) // R11
        else $error("servo-off did not apply brake");
    zero_delay_a: assert property (st_ff.mode == bsq_pkg::BSQ_ON && !st_ff.son_s && stopped
        && dly_v == '0 |=> !motor_power_on) // R21
        else $error("zero delay kept power");
    ot_brake_a: assert property (brake_release_out && st_ff.son_s && !st_ff.alm_s
        && st_ff.mode == bsq_pkg::BSQ_ON |=> brake_release_out) // R07
        else $error("brake applied without cause");
    dly_power_a: assert property ($rose(st_ff.mode == bsq_pkg::BSQ_DLY)
        |-> motor_power_on && !brake_release_out) // R12
        else $error("delay mode output mismatch");
    rot_speed_a: assert property (st_ff.mode == bsq_pkg::BSQ_ROT && 16'(motor_speed) < thr_v
        |=> !brake_release_out && !motor_power_on) // R16
        else $error("brake not applied below threshold");
    route_hold_a: assert property (!$past(sys_rst) |-> $stable(st_ff.route_act)) // R20
        else $error("routing copy changed without restart");
    term_or_a: assert property (term_out[0] == (other_out[0] |
        (brake_release_out & st_ff.route_act == 2'h1))) // R10
        else $error("terminal one level wrong");
    warn_power_a: assert property ($rose(ot_warning) |-> $past(pwr_on)) // R19
        else $error("warning raised with power off");
    ot_stop_a: assert property (st_ff.fwd_s ##1 st_ff.fwd_s |-> ot_stop_fwd) // R03
        else $error("forward stop not requested");

    servo_cycle_c: cover property (st_ff.mode == bsq_pkg::BSQ_ON ##1
        st_ff.mode == bsq_pkg::BSQ_DLY);
    rotating_c: cover property (st_ff.mode == bsq_pkg::BSQ_ROT ##1
        st_ff.mode == bsq_pkg::BSQ_OFF);
    warn_c: cover property ($rose(ot_warning));
    routed_c: cover property (brake_release_out && st_ff.route_act == 2'h3);
endmodule

/* verif/bsq_host_model.sv */
`timescale 1ns/10ps
// host controller and brake relay seen from the drive's pins
module bsq_host_model
#(
    parameter int unsigned TICK_CYCLES = 10 // cycles per 10 ms unit
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic want_on, // bench asks the host for servo-on
    input wire logic want_fwd, // bench asks for a forward reference
    input wire logic want_rev, // bench asks for a reverse reference
    input wire logic brake_release_out,
    output logic servo_on_in,
    output logic ref_fwd,
    output logic ref_rev,
    output logic brake_engaged
);
    localparam int unsigned SETTLE = 5 * TICK_CYCLES; // 50 ms in cycles
    int unsigned rel_cnt_ff; // cycles since the brake was released
    logic ready; // reference may be issued

    // count how long the brake has been released, restart when applied
    always_ff @(posedge clk)
    begin
        if (sys_rst || !brake_release_out)
            rel_cnt_ff <= 0;
        else if (rel_cnt_ff < SETTLE)
            rel_cnt_ff <= rel_cnt_ff + 1;
    end

    // no reference before servo-on and 50 ms of released brake
    assign ready = servo_on_in && (rel_cnt_ff >= SETTLE);

    // host outputs change only on the clock, like a real controller
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            servo_on_in <= 1'b0;
            ref_fwd <= 1'b0;
            ref_rev <= 1'b0;
        end
        else
        begin
            servo_on_in <= want_on;
            ref_fwd <= want_fwd && ready;
            ref_rev <= want_rev && ready && !want_fwd;
        end
    end

    // relay: closed contact releases, open contact applies
    assign brake_engaged = !brake_release_out;
endmodule

/* verif/servo_brake_sequencer_bench.sv */
`timescale 1ns/10ps
// register tasks and pin sequences against the brake sequencer
module servo_brake_sequencer_bench;
    localparam int unsigned TK = 10; // short tick keeps the run small
    logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rv;
    logic alarm_in = 1'b0, fwd_limit_in = 1'b0, rev_limit_in = 1'b0;
    logic want_on = 1'b0, want_fwd = 1'b0, want_rev = 1'b0;
    logic [13:0] motor_speed = 14'h0000;
    logic [2:0] other_out = 3'h0, term_out;
    logic servo_on_in, ref_fwd, ref_rev, brake_release_out, motor_power_on;
    logic ot_stop_fwd, ot_stop_rev, ot_warning, brake_engaged;
    int error_cnt = 0, samples_checked = 0, n;
    logic [2:0] exp_t; // expected terminal levels

    always #10 clk = ~clk;

    bsq_sequencer #(.TICK_CYCLES(TK), .SPD_W(14)) dut (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .servo_on_in(servo_on_in), .alarm_in(alarm_in),
        .fwd_limit_in(fwd_limit_in), .rev_limit_in(rev_limit_in), .motor_speed(motor_speed),
        .ref_fwd(ref_fwd), .ref_rev(ref_rev), .other_out(other_out), .term_out(term_out),
        .brake_release_out(brake_release_out), .motor_power_on(motor_power_on),
        .ot_stop_fwd(ot_stop_fwd), .ot_stop_rev(ot_stop_rev), .ot_warning(ot_warning));

    bsq_host_model #(.TICK_CYCLES(TK)) host (.clk(clk), .sys_rst(sys_rst), .want_on(want_on),
        .want_fwd(want_fwd), .want_rev(want_rev), .brake_release_out(brake_release_out),
        .servo_on_in(servo_on_in), .ref_fwd(ref_fwd), .ref_rev(ref_rev),
        .brake_engaged(brake_engaged));

    // verdict and end of run, shared by main flow and timeouts
    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one comparison, four-state exact
    task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // synchronous reset held for ten cycles
    task rst;
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
    endtask

    // single-cycle write strobe
    task wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read strobe, data looked at mid-cycle of the following cycle
    task rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    // bounded wait: 0 brake, 1 power, 2 warning, 3 forward reference, 4 reverse reference
    task wait_for(input int sel, input logic v, input int lim, output int cnt);
        logic s;
        for (cnt = 0; cnt <= lim; cnt++)
        begin
            @(posedge clk);
            #1;
            case (sel)
                0: s = brake_release_out;
                1: s = motor_power_on;
                2: s = ot_warning;
                3: s = ref_fwd;
                default: s = ref_rev;
            endcase
            if (s === v)
                return;
        end
        error_cnt++;
        $display("[ERR] wait %0d expected %b seen timeout", sel, v);
        final_report();
    endtask

    // servo on and wait for release
    task up;
        want_on <= 1'b1;
        wait_for(0, 1'b1, 10, n);
    endtask

    initial
    begin
        rst();
        wr(bsq_pkg::A_ROUTE, 16'h0000);
        rst();
        rd(bsq_pkg::A_OTW, rv); chk("otw rst", rv, bsq_pkg::OTW_RST);
        rd(bsq_pkg::A_DLY, rv); chk("dly rst", rv, 16'h0000);
        rd(bsq_pkg::A_THR, rv); chk("thr rst", rv, 16'h0064);
        rd(bsq_pkg::A_WAIT, rv); chk("wait rst", rv, 16'h0032);
        rd(5'h18, rv); chk("unmapped", rv, 16'h0000);
        wr(bsq_pkg::A_DLY, 16'h0033);
        // stored as written, the range limit acts only where the delay is used
        rd(bsq_pkg::A_DLY, rv); chk("dly raw", rv, 16'h0033);
        wr(bsq_pkg::A_DLY, 16'h0000);
        // every allocation, shared terminal, late write ignored until reset
        for (int s = 0; s < 4; s++)
        begin
            wr(bsq_pkg::A_ROUTE, 16'(s) << 8);
            rst();
            other_out <= 3'b010;
            up();
            wr(bsq_pkg::A_ROUTE, 16'((s + 1) % 4) << 8);
            exp_t = 3'b010 | ((s == 0) ? 3'b000 : (3'b001 << (s - 1)));
            chk("term", term_out, exp_t);
            chk("relay", brake_engaged, 1'b0);
            want_on <= 1'b0;
            wait_for(0, 1'b0, 10, n);
            chk("pwr same edge", motor_power_on, 1'b0);
            chk("term off", term_out, 3'b010);
        end
        // stopped servo-off with two units of delay, vertical axis style
        wr(bsq_pkg::A_DLY, 16'h0002);
        up();
        want_on <= 1'b0;
        wait_for(0, 1'b0, 10, n);
        chk("pwr held", motor_power_on, 1'b1);
        wait_for(1, 1'b0, 40, n);
        chk("dly span", 16'((n >= TK - 1) && (n <= 2 * TK + 2)), 16'h0001);
        // alarm in mid-delay cuts power at once
        wr(bsq_pkg::A_DLY, 16'h0032);
        up();
        want_on <= 1'b0;
        wait_for(0, 1'b0, 10, n);
        alarm_in <= 1'b1;
        wait_for(1, 1'b0, 5, n);
        // alarm with servo on: brake and power both drop, servo-on refused
        alarm_in <= 1'b0;
        wr(bsq_pkg::A_DLY, 16'h0000);
        up();
        alarm_in <= 1'b1;
        wait_for(0, 1'b0, 6, n);
        chk("alarm pwr", motor_power_on, 1'b0);
        repeat (8) @(posedge clk);
        chk("alarm hold", brake_release_out, 1'b0);
        alarm_in <= 1'b0;
        wait_for(0, 1'b1, 8, n);
        // rotating stop ended by speed threshold
        motor_speed <= 14'd500;
        want_on <= 1'b0;
        wait_for(1, 1'b0, 8, n);
        chk("rot held", brake_release_out, 1'b1);
        // status: mode rotating, routing copy 3, brake released, power off
        rd(bsq_pkg::A_STAT, rv); chk("status rot", rv, 16'h001f);
        motor_speed <= 14'd50;
        wait_for(0, 1'b0, 4, n);
        // rotating stop ended by wait timeout of ten units
        motor_speed <= 14'd0;
        wr(bsq_pkg::A_WAIT, 16'h000a);
        up();
        motor_speed <= 14'd500;
        want_on <= 1'b0;
        wait_for(1, 1'b0, 8, n);
        wait_for(0, 1'b0, 130, n);
        chk("wait span", 16'((n >= 9 * TK - 2) && (n <= 10 * TK + 3)), 16'h0001);
        motor_speed <= 14'd0;
        // overtravel with warning disabled, then enabled
        want_fwd <= 1'b1;
        up();
        fwd_limit_in <= 1'b1;
        repeat (8) @(posedge clk);
        chk("stop fwd", ot_stop_fwd, 1'b1);
        chk("ot brake", brake_release_out, 1'b1);
        chk("warn off", ot_warning, 1'b0);
        fwd_limit_in <= 1'b0;
        wr(bsq_pkg::A_OTW, 16'h1000);
        wait_for(3, 1'b1, 80, n);
        rev_limit_in <= 1'b1;
        repeat (8) @(posedge clk);
        chk("stop rev", ot_stop_rev, 1'b1);
        chk("warn dir", ot_warning, 1'b0);
        rev_limit_in <= 1'b0;
        fwd_limit_in <= 1'b1;
        wait_for(2, 1'b1, 8, n);
        rd(bsq_pkg::A_OTW, rv); chk("bus during warn", rv, 16'h1000);
        chk("warn brake", brake_release_out, 1'b1);
        fwd_limit_in <= 1'b0;
        repeat (90 * TK) @(posedge clk);
        chk("warn hold", ot_warning, 1'b1);
        wait_for(2, 1'b0, 20 * TK, n);
        fwd_limit_in <= 1'b1;
        wait_for(2, 1'b1, 8, n);
        wr(bsq_pkg::A_OTW, 16'h0000);
        wait_for(2, 1'b0, 3, n);
        // limit hit with power off raises no warning
        fwd_limit_in <= 1'b0;
        want_fwd <= 1'b0;
        want_on <= 1'b0;
        wait_for(1, 1'b0, 10, n);
        wr(bsq_pkg::A_OTW, 16'h1000);
        fwd_limit_in <= 1'b1;
        repeat (8) @(posedge clk);
        chk("warn pwr off", ot_warning, 1'b0);
        // reverse reference: forward limit ignored, reverse limit flagged
        fwd_limit_in <= 1'b0;
        want_rev <= 1'b1;
        up();
        wait_for(4, 1'b1, 80, n);
        fwd_limit_in <= 1'b1;
        repeat (8) @(posedge clk);
        chk("warn rev ref", ot_warning, 1'b0);
        rev_limit_in <= 1'b1;
        wait_for(2, 1'b1, 8, n);
        final_report();
    end
endmodule
